/* hdl/ppfc_pkg.sv */
// Purpose: constants for the port pin function control block
// Assumes: byte-wide register port, 9 ports packed 8 pins apiece
// Notes: unbuilt pin slots read as zero and are never driven
package ppfc_pkg;
   ////////////////////////////////////////////////////////////////
   // Port slots, in pin-vector order
   localparam int NPORT = 9;
   localparam int PINW = 72;
   localparam int IX_P0 = 0;
   localparam int IX_P1 = 1;
   localparam int IX_P2 = 2;
   localparam int IX_P3 = 3;
   localparam int IX_P7 = 4;
   localparam int IX_P8 = 5;
   localparam int IX_P9 = 6;
   localparam int IX_P10 = 7;
   localparam int IX_P11 = 8;
   localparam logic [3:0] NPORT_L = 4'h9;
   // Built pins per slot, slot 8 first
   localparam logic [8:0][7:0] IMPL_MASK = {8'hFF, 8'h0F, 8'hFF,
      8'hFF, 8'h07, 8'hFF, 8'hE0, 8'hFF, 8'hBF};
   localparam logic [7:0] P0_IN_ONLY = 8'h81;
   localparam logic [7:0] P3_ALT_OUT = 8'h67;
   ////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] A_LATCH = 8'h00;
   localparam logic [7:0] A_MODE = 8'h10;
   localparam logic [7:0] A_ALT = 8'h20;
   localparam logic [7:0] A_PIN = 8'h30;
   localparam logic [7:0] A_PUL = 8'h40;
   localparam logic [7:0] A_PUH = 8'h41;
   localparam logic [7:0] A_ANA = 8'h42;
   localparam logic [7:0] A_EDR = 8'h43;
   localparam logic [7:0] A_EDF = 8'h44;
   localparam logic [7:0] A_LCDC = 8'h45;
   localparam logic [7:0] A_LCDM = 8'h46;
   localparam logic [7:0] A_STAT = 8'h47;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'hFF;
   localparam logic [7:0] LATCH_RST = 8'h00;
   ////////////////////////////////////////////////////////////////
   // LCD mode fields and common-output sets
   localparam int LM_STATIC = 0;
   localparam int LM_THIRD = 1;
   localparam int LM_TD = 2;
   localparam logic [1:0] TD2 = 2'h0;
   localparam logic [1:0] TD3 = 2'h1;
   localparam logic [1:0] TD4 = 2'h2;
   localparam logic [3:0] COM_ALL = 4'hF;
   localparam logic [3:0] COM_2 = 4'h3;
   localparam logic [3:0] COM_3 = 4'h7;
   localparam int ST_FLAG = 0;
endpackage : ppfc_pkg

/* hdl/ppfc_top.sv */
// Purpose: pin direction, alternate function and pull-up control
// Assumes: single clock, synchronous active-low reset
// Notes: pin k*8+b is bit b of port slot k
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module ppfc_top
   import ppfc_pkg::*;
(
   input wire logic clk_i,                           // 100 MHz clock
   input wire logic rst_b_i,                         // Sync reset, low
   input wire logic [7:0] addr_i,                    // Register address
   input wire logic [7:0] wdata_i,                   // Write data
   input wire logic wstrb_i,                         // Write strobe
   input wire logic rstrb_i,                         // Read strobe
   output logic [7:0] rdata_o,                       // Read data, +1 cycle
   input wire logic [PINW-1:0] pin_in_i,             // Pad levels
   output logic [PINW-1:0] pin_out_o,                // Pad drive value
   output logic [PINW-1:0] pin_oe_o,                 // Pad drive enable
   output logic [PINW-1:0] pin_pu_o,                 // Pull-up enable
   input wire logic [2:0] timer_out_i,               // Timer outputs
   input wire logic clock_out_pin_i,                 // Clock output
   input wire logic buzzer_out_pin_i,                // Buzzer output
   input wire logic ser0_data_out_i,                 // Serial 0 data out
   input wire logic ser0_clock_pin_i,                // Serial 0 clock out
   input wire logic ser2_data_out_i,                 // Serial 2 data out
   input wire logic ser2_clock_pin_i,                // Serial 2 clock out
   input wire logic [7:0] lcd_segment_hi_outs_i,     // Segments 32-39
   input wire logic [7:0] lcd_segment_mid_outs_i,    // Segments 24-31
   output logic [5:0] ext_irq_in_o,                  // Valid edge pulses
   output logic t16_capture_pulse_o,                 // Capture by edge
   output logic t16_count_clock_in_o,                // Timer count clock
   output logic t16_capture_trigger_in_o,            // Capture pin level
   output logic t8a_clock_in_o,                      // 8-bit timer A clk
   output logic t8b_clock_in_o,                      // 8-bit timer B clk
   output logic ser0_data_in_o,                      // Serial 0 data in
   output logic ser0_clock_in_o,                     // Serial 0 clock in
   output logic ser2_data_in_o,                      // Serial 2 data in
   output logic async_clock_in_o,                    // Async serial clk
   output logic [7:0] analog_in_pins_o,              // Analog enables
   output logic [3:0] lcd_common_outs_o,             // Active commons
   output logic port11_fall_edge_flag_o              // Falling edge flag
);

   ////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [8:0][7:0] lat;
      logic [8:0][7:0] pm;
      logic [8:0][7:0] alt;
      logic [4:0] pul;
      logic [3:0] puh;
      logic [7:0] ana;
      logic [5:0] edr;
      logic [5:0] edf;
      logic [7:0] lcdc;
      logic [3:0] lcdm;
      logic kflag;
      logic [PINW-1:0] s1;
      logic [PINW-1:0] s2;
      logic [PINW-1:0] prev;
      logic [PINW-1:0] pout;
      logic [PINW-1:0] poe;
      logic [PINW-1:0] ppu;
      logic [7:0] rdata;
      logic [5:0] irq;
      logic cap;
      logic [3:0] com;
      logic t16clk;
      logic t16trg;
      logic t8a;
      logic t8b;
      logic s0di;
      logic s0ck;
      logic s2di;
      logic s2ck;
   } ppfc_state_t;

   ppfc_state_t st;
   ppfc_state_t next_st;

   ////////////////////////////////////////////////////////////////
   // Helpers
   // Per-port register window hit
   function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
      hit = (a[7:4] == base[7:4]) && (a[3:0] < NPORT_L);
   endfunction : hit

   // Common outputs for the LCD drive mode
   function automatic logic [3:0] com_sel(input logic [3:0] m);
      logic [1:0] td;
      td = m[LM_TD+:2];
      com_sel = 4'h0;
      if (m[LM_STATIC]) begin
         com_sel = COM_ALL;
      end else if (!m[LM_THIRD]) begin
         if (td == TD2) begin
            com_sel = COM_2;
         end else if (td == TD3) begin
            com_sel = COM_3;
         end
      end else begin
         if (td == TD3) begin
            com_sel = COM_3;
         end else if (td == TD4) begin
            com_sel = COM_ALL;
         end
      end
   endfunction : com_sel

   ////////////////////////////////////////////////////////////////
   // Next-state logic
   logic [7:0] p3alt;
   logic [PINW-1:0] rise;
   logic [PINW-1:0] fall;
   logic [PINW-1:0] impl;
   logic ctl;
   logic val;
   logic oe;
   logic opt;
   int i;

   always_comb begin
      next_st = st;
      p3alt = {1'b0, buzzer_out_pin_i, clock_out_pin_i, 2'b00, timer_out_i};
      impl = IMPL_MASK;
      ctl = 1'b0;
      val = 1'b0;
      oe = 1'b0;
      opt = 1'b0;
      i = 0;

      // Pad synchroniser and edge history
      next_st.s1 = pin_in_i;
      next_st.s2 = st.s1;
      next_st.prev = st.s2;
      rise = st.s2 & ~st.prev & impl;
      fall = ~st.s2 & st.prev & impl;

      // Register writes
      if (wstrb_i) begin
         if (hit(addr_i, A_LATCH)) begin
            next_st.lat[addr_i[3:0]] = wdata_i;
         end
         if (hit(addr_i, A_MODE)) begin
            next_st.pm[addr_i[3:0]] = wdata_i;
         end
         if (hit(addr_i, A_ALT)) begin
            next_st.alt[addr_i[3:0]] = wdata_i;
         end
         unique case (addr_i)
            A_PUL: next_st.pul = wdata_i[4:0];
            A_PUH: next_st.puh = wdata_i[3:0];
            A_ANA: next_st.ana = wdata_i;
            A_EDR: next_st.edr = wdata_i[5:0];
            A_EDF: next_st.edf = wdata_i[5:0];
            A_LCDC: next_st.lcdc = wdata_i;
            A_LCDM: next_st.lcdm = wdata_i[3:0];
            A_STAT: begin
               if (wdata_i[ST_FLAG]) begin
                  next_st.kflag = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // Falling edge on port 11 sets flag; set beats clear
      if (|fall[IX_P11*8+:8]) begin
         next_st.kflag = 1'b1;
      end

      // Register reads, data valid the following cycle only
      next_st.rdata = 8'h00;
      if (rstrb_i) begin
         if (hit(addr_i, A_LATCH)) begin
            next_st.rdata = st.lat[addr_i[3:0]];
         end else if (hit(addr_i, A_MODE)) begin
            next_st.rdata = st.pm[addr_i[3:0]];
         end else if (hit(addr_i, A_ALT)) begin
            next_st.rdata = st.alt[addr_i[3:0]];
         end else if (hit(addr_i, A_PIN)) begin
            next_st.rdata = st.s2[addr_i[3:0]*8+:8] & IMPL_MASK[addr_i[3:0]];
         end else begin
            unique case (addr_i)
               A_PUL: next_st.rdata = {3'h0, st.pul};
               A_PUH: next_st.rdata = {4'h0, st.puh};
               A_ANA: next_st.rdata = st.ana;
               A_EDR: next_st.rdata = {2'h0, st.edr};
               A_EDF: next_st.rdata = {2'h0, st.edf};
               A_LCDC: next_st.rdata = st.lcdc;
               A_LCDM: next_st.rdata = {4'h0, st.lcdm};
               A_STAT: next_st.rdata = {7'h00, st.kflag};
               default: next_st.rdata = 8'h00;
            endcase
         end
      end

      // Per-pin drive, enable and pull-up
      for (int k = 0; k < NPORT; k++) begin
         for (int b = 0; b < 8; b++) begin
            i = k * 8 + b;
            ctl = st.alt[k][b];
            val = st.lat[k][b];
            oe = ~st.pm[k][b];
            unique case (k)
               IX_P0: begin
                  // Control mode pins are interrupt or timer inputs
                  oe = oe & ~ctl & ~P0_IN_ONLY[b];
               end
               IX_P1: begin
                  ctl = st.ana[b];
                  oe = oe & ~ctl;
               end
               IX_P2: begin
                  // Direction stays with software in serial use
                  if (ctl && b == 6) begin
                     val = ser0_data_out_i;
                  end else if (ctl && b == 7) begin
                     val = ser0_clock_pin_i;
                  end
               end
               IX_P3: begin
                  if (ctl) begin
                     val = p3alt[b];
                     oe = P3_ALT_OUT[b];
                  end
               end
               IX_P7: begin
                  if (ctl && b == 1) begin
                     val = ser2_data_out_i;
                  end else if (ctl && b == 2) begin
                     val = ser2_clock_pin_i;
                  end
               end
               IX_P8: begin
                  ctl = st.lcdc[b/2];
                  if (ctl) begin
                     val = lcd_segment_hi_outs_i[7-b];
                     oe = 1'b1;
                  end
               end
               IX_P9: begin
                  ctl = st.lcdc[4+b/2];
                  if (ctl) begin
                     val = lcd_segment_mid_outs_i[7-b];
                     oe = 1'b1;
                  end
               end
               IX_P10, IX_P11: ;
               default: ;
            endcase
            oe = oe & impl[i];
            // Pull-up option per port group
            if (k <= IX_P7) begin
               opt = st.pul[k];
            end else begin
               opt = st.puh[k-IX_P8];
            end
            next_st.pout[i] = val & oe;
            next_st.poe[i] = oe;
            // Only on an undriven, non-analog input
            next_st.ppu[i] = opt & ~oe & impl[i] & ~(k == IX_P1 && st.ana[b]);
         end
      end

      // Valid-edge selection for the six interrupt inputs
      next_st.irq = (rise[5:0] & st.edr) | (fall[5:0] & st.edf);
      next_st.cap = next_st.irq[0] | next_st.irq[1];

      // Peripheral input levels in control mode
      next_st.t16clk = st.alt[IX_P0][0] & st.s2[0];
      next_st.t16trg = st.alt[IX_P0][1] & st.s2[1];
      next_st.t8a = st.alt[IX_P3][3] & st.s2[IX_P3*8+3];
      next_st.t8b = st.alt[IX_P3][4] & st.s2[IX_P3*8+4];
      next_st.s0di = st.alt[IX_P2][5] & st.s2[IX_P2*8+5];
      next_st.s0ck = st.alt[IX_P2][7] & st.s2[IX_P2*8+7];
      next_st.s2di = st.alt[IX_P7][0] & st.s2[IX_P7*8];
      next_st.s2ck = st.alt[IX_P7][2] & st.s2[IX_P7*8+2];
      next_st.com = com_sel(st.lcdm);
   end

   ////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st <= '0;
         st.pm <= {NPORT{MODE_RST}};
         st.lat <= {NPORT{LATCH_RST}};
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs
   assign rdata_o = st.rdata;
   assign pin_out_o = st.pout;
   assign pin_oe_o = st.poe;
   assign pin_pu_o = st.ppu;
   assign ext_irq_in_o = st.irq;
   assign t16_capture_pulse_o = st.cap;
   assign t16_count_clock_in_o = st.t16clk;
   assign t16_capture_trigger_in_o = st.t16trg;
   assign t8a_clock_in_o = st.t8a;
   assign t8b_clock_in_o = st.t8b;
   assign ser0_data_in_o = st.s0di;
   assign ser0_clock_in_o = st.s0ck;
   assign ser2_data_in_o = st.s2di;
   assign async_clock_in_o = st.s2ck;
   assign analog_in_pins_o = st.ana;
   assign lcd_common_outs_o = st.com;
   assign port11_fall_edge_flag_o = st.kflag;

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // Input-only port 0 pins never drive
   property p_p0_in_only;
      (pin_oe_o[0] == 1'b0) && (pin_oe_o[7] == 1'b0) && (pin_oe_o[6] == 1'b0);
   endproperty
   a_p0_in_only: assert property (p_p0_in_only)
      else $error("port 0 input-only pin driven");

   // Output mode on a plain pin enables the driver
   property p_dir_out;
      (st.pm[IX_P10][0] == 1'b0) |=> pin_oe_o[IX_P10*8];
   endproperty
   a_dir_out: assert property (p_dir_out)
      else $error("port 10 pin not driving in output mode");

   // Pull-up follows low option on an input pin
   property p_pu_low;
      (st.pul[IX_P0] && st.pm[IX_P0][1] && !st.alt[IX_P0][1]) |=> pin_pu_o[1];
   endproperty
   a_pu_low: assert property (p_pu_low)
      else $error("low pull-up option not applied");

   // Pull-up follows high option on an input pin
   property p_pu_high;
      (st.puh[IX_P11-IX_P8] && st.pm[IX_P11][0]) |=> pin_pu_o[IX_P11*8];
   endproperty
   a_pu_high: assert property (p_pu_high)
      else $error("high pull-up option not applied");

   // Analog pins never pull up
   property p_ana_pu;
      (st.ana != 8'h00) |=> ((pin_pu_o[15:8] & $past(st.ana)) == 8'h00);
   endproperty
   a_ana_pu: assert property (p_ana_pu)
      else $error("pull-up on analog input");

   // Rising edge on interrupt 0 gives one pulse
   property p_irq_rise;
      (st.s2[0] && !st.prev[0] && st.edr[0]) |=> ext_irq_in_o[0] ##1 (!ext_irq_in_o[0] || $past(st.edf[0]));
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("rising edge missed on interrupt 0");

   // Valid rising edge on interrupt 1 fires a capture
   property p_capture;
      (st.s2[1] && !st.prev[1] && st.edr[1]) |=> t16_capture_pulse_o;
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture pulse mismatch");

   // Segment data reaches port 8 pin 0
   property p_seg;
      st.lcdc[0] |=> pin_out_o[IX_P8*8] == $past(lcd_segment_hi_outs_i[7]);
   endproperty
   a_seg: assert property (p_seg)
      else $error("segment 39 not on port 8 pin 0");

   // Port 11 falling edge sets the flag
   property p_kflag;
      (st.prev[IX_P11*8+:8] & ~st.s2[IX_P11*8+:8]) != 8'h00 |=> port11_fall_edge_flag_o;
   endproperty
   a_kflag: assert property (p_kflag)
      else $error("port 11 falling edge lost");

   // Static mode lights all commons
   property p_static;
      st.lcdm[LM_STATIC] |=> lcd_common_outs_o == COM_ALL;
   endproperty
   a_static: assert property (p_static)
      else $error("static mode commons wrong");

   // Third bias, four-way uses all commons
   property p_third4;
      (st.lcdm == {TD4, 1'b1, 1'b0}) |=> lcd_common_outs_o == COM_ALL;
   endproperty
   a_third4: assert property (p_third4)
      else $error("third bias four-way commons wrong");

   // Released from reset with no drive and no pull-up
   property p_rst;
      !$past(rst_b_i) |-> (pin_oe_o == '0) && (pin_pu_o == '0) && (st.alt == '0);
   endproperty
   a_rst: assert property (p_rst)
      else $error("pins not quiet after reset");

endmodule : ppfc_top

/* tb/ppfc_board.sv */
// Purpose: board-side pad model for the port block
// Assumes: device drive wins, then board drive, then pull-up
// Notes: an undriven pad with no pull-up toggles every cycle
`timescale 1ns/10ps
module ppfc_board (
   input wire logic clk_i,            // Bench clock
   input wire logic [71:0] out_i,     // Device drive value
   input wire logic [71:0] oe_i,      // Device drive enable
   input wire logic [71:0] pu_i,      // Device pull-up
   input wire logic [71:0] ext_i,     // Board drive value
   input wire logic [71:0] ext_en_i,  // Board drive enable
   output logic [71:0] pad_o          // Resolved pad level
);
   logic [71:0] flt = '0;
   // Floating pads wander so a stale level never passes
   always @(posedge clk_i) begin
      flt <= ~flt;
   end
   // Resolve each pad from all its drivers
   always_comb begin
      for (int i = 0; i < 72; i++) begin
         pad_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] : pu_i[i] ? 1'b1 : flt[i];
      end
   end
endmodule : ppfc_board

/* tb/tb_top.sv */
// Purpose: self-checking bench for the port pin block
// Assumes: byte register port, read data one cycle after strobe
// Notes: register reads are checked from a queue by a monitor
`timescale 1ns/10ps
module tb_top
   import ppfc_pkg::*;
;
   logic clk_i, rst_b_i, wstrb_i, rstrb_i;
   logic [7:0] addr_i, wdata_i, rdata_o, seg_hi, seg_mid, ana, m, l, e, oe8, rexp;
   logic [PINW-1:0] pin_in_i, pin_out_o, pin_oe_o, pin_pu_o, ext, ext_en, pe;
   logic [2:0] timer_out_i;
   logic clk_out, buzzer_out_pin, s0do, s0co, s2do, s2co;
   logic [5:0] irq;
   logic cap, cnt_clk, trig, t8a, t8b, s0d, s0c, s2d, aclk, flag;
   logic [3:0] coms;
   logic rd_q = 1'b0;
   logic [7:0] rq[$];
   logic [31:0] seed = 32'hC53FA625;
   logic [7:0] lv [7] = '{8'h01, 8'h00, 8'h04, 8'h06, 8'h0A, 8'h08, 8'h02};
   logic [3:0] lc [7] = '{COM_ALL, COM_2, COM_3, COM_3, COM_ALL, 4'h0, 4'h0};
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_irq, n_cap, cur_b, x;
   ////////////////////////////////////////////////////////////////
   ppfc_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wstrb_i(wstrb_i), .rstrb_i(rstrb_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o),
      .timer_out_i(timer_out_i), .clock_out_pin_i(clk_out), .buzzer_out_pin_i(buzzer_out_pin),
      .ser0_data_out_i(s0do), .ser0_clock_pin_i(s0co), .ser2_data_out_i(s2do),
      .ser2_clock_pin_i(s2co), .lcd_segment_hi_outs_i(seg_hi),
      .lcd_segment_mid_outs_i(seg_mid), .ext_irq_in_o(irq), .t16_capture_pulse_o(cap),
      .t16_count_clock_in_o(cnt_clk), .t16_capture_trigger_in_o(trig),
      .t8a_clock_in_o(t8a), .t8b_clock_in_o(t8b), .ser0_data_in_o(s0d),
      .ser0_clock_in_o(s0c), .ser2_data_in_o(s2d), .async_clock_in_o(aclk),
      .analog_in_pins_o(ana), .lcd_common_outs_o(coms), .port11_fall_edge_flag_o(flag));
   ppfc_board board (.clk_i(clk_i), .out_i(pin_out_o), .oe_i(pin_oe_o), .pu_i(pin_pu_o),
      .ext_i(ext), .ext_en_i(ext_en), .pad_o(pin_in_i));
   // Clock source
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      conclude();
   end
   // Pulse counters and read data monitor
   always @(posedge clk_i) begin
      if (irq[cur_b] === 1'b1) n_irq++;
      if (cap === 1'b1) n_cap++;
      if (rd_q) begin
         rexp = rq.pop_front();
         cmp_count++;
         if (rdata_o !== rexp) begin
            n_mismatch++;
            $display("BAD rdata expected %h seen %h", rexp, rdata_o);
         end
      end
      rd_q <= rstrb_i;
   end
   ////////////////////////////////////////////////////////////////
   task automatic rnd(output logic [7:0] v);
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
      v = seed[7:0];
   endtask : rnd
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle
   task automatic chk(input string nm, input logic [71:0] ex, input logic [71:0] got);
      cmp_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wstrb_i <= 1'b1;
      @(posedge clk_i);
      wstrb_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] ex);
      rq.push_back(ex);
      @(posedge clk_i);
      addr_i <= a;
      rstrb_i <= 1'b1;
      @(posedge clk_i);
      rstrb_i <= 1'b0;
   endtask : rd
   task automatic conclude();
      $display("Mismatches %0d of %0d comparisons", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_b_i = 1'b0;
      wstrb_i = 1'b0;
      rstrb_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      ext = '0;
      ext_en = '1;
      timer_out_i = 3'h0;
      {clk_out, buzzer_out_pin, s0do, s0co, s2do, s2co} = 6'h00;
      seg_hi = 8'h00;
      seg_mid = 8'h00;
      cur_b = 0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      // Reset state of every slot
      for (int k = 0; k < NPORT; k++) begin
         rd(A_MODE + 8'(k), MODE_RST);
         rd(A_LATCH + 8'(k), LATCH_RST);
         rd(A_ALT + 8'(k), 8'h00);
      end
      chk("oe", '0, pin_oe_o);
      chk("pu", '0, pin_pu_o);
      rd(8'hFF, 8'h00);
      // Random direction, latch and pad levels per slot
      for (int k = 0; k < NPORT; k++) begin
         rnd(m);
         rnd(l);
         rnd(e);
         wr(A_MODE + 8'(k), m);
         wr(A_LATCH + 8'(k), l);
         ext[k*8 +: 8] <= e;
         idle(4);
         oe8 = ~m & IMPL_MASK[k] & ((k == IX_P0) ? ~P0_IN_ONLY : 8'hFF);
         chk("oe", 72'(oe8), 72'(pin_oe_o[k*8 +: 8]));
         chk("out", 72'(oe8 & l), 72'(pin_out_o[k*8 +: 8]));
         rd(A_PIN + 8'(k), ((l & oe8) | (e & ~oe8)) & IMPL_MASK[k]);
         wr(A_MODE + 8'(k), 8'hFF);
      end
      // Pull-ups with the board released
      ext_en <= '0;
      wr(A_PUL, 8'h1F);
      idle(3);
      pe = IMPL_MASK;
      pe[40 +: 32] = '0;
      chk("pu_low", pe, pin_pu_o);
      wr(A_PUH, 8'h0F);
      idle(3);
      chk("pu_all", IMPL_MASK, pin_pu_o);
      rd(A_PIN + 8'(IX_P10), 8'h0F);
      wr(A_ANA, 8'hFF);
      wr(A_MODE + 8'(IX_P11), 8'h00);
      idle(3);
      pe = IMPL_MASK;
      pe[8 +: 8] = '0;
      pe[64 +: 8] = '0;
      chk("pu_gate", pe, pin_pu_o);
      chk("ana", 72'(8'hFF), 72'(ana));
      wr(A_ANA, 8'h00);
      wr(A_MODE + 8'(IX_P11), 8'hFF);
      wr(A_PUL, 8'h00);
      wr(A_PUH, 8'h00);
      ext_en <= '1;
      // Edge modes on all six interrupt inputs
      for (int b = 0; b < 6; b++) begin
         cur_b = b;
         for (int md = 1; md < 4; md++) begin
            wr(A_EDR, md[0] ? 8'(1 << b) : 8'h00);
            wr(A_EDF, md[1] ? 8'(1 << b) : 8'h00);
            ext[b] <= 1'b0;
            idle(6);
            n_irq = 0;
            n_cap = 0;
            ext[b] <= 1'b1;
            idle(6);
            ext[b] <= 1'b0;
            idle(6);
            x = (md & 1) + (md >> 1);
            chk("irq", 72'(x), 72'(n_irq));
            chk("cap", 72'(b < 2 ? x : 0), 72'(n_cap));
         end
      end
      wr(A_EDR, 8'h00);
      wr(A_EDF, 8'h00);
      // Falling edge flag on the last slot
      ext[64 +: 8] <= 8'hFF;
      idle(6);
      wr(A_STAT, 8'h01);
      idle(2);
      rd(A_STAT, 8'h00);
      ext[67] <= 1'b0;
      idle(6);
      chk("flag", 72'(1), 72'(flag));
      rd(A_STAT, 8'h01);
      wr(A_STAT, 8'h01);
      idle(2);
      rd(A_STAT, 8'h00);
      // Common outputs per bias and division
      for (int i = 0; i < 7; i++) begin
         wr(A_LCDM, lv[i]);
         idle(2);
         chk("com", 72'(lc[i]), 72'(coms));
      end
      // Segment pairs on the two LCD ports
      rnd(m);
      rnd(l);
      seg_hi <= m;
      seg_mid <= l;
      wr(A_LCDC, 8'h21);
      idle(3);
      chk("seg_oe", 72'(16'h0C03), 72'(pin_oe_o[40 +: 16]));
      chk("seg", 72'({4'h0, l[4], l[5], 8'h00, m[6], m[7]}), 72'(pin_out_o[40 +: 16]));
      wr(A_LCDC, 8'h00);
      // Control mode on timer and serial pins
      ext[1:0] <= 2'b01;
      ext[28:27] <= 2'b01;
      ext[34:32] <= 3'b001;
      timer_out_i <= 3'h5;
      clk_out <= 1'b1;
      buzzer_out_pin <= 1'b0;
      s2do <= 1'b1;
      s0do <= 1'b1;
      s0co <= 1'b1;
      ext[21] <= 1'b1;
      wr(A_ALT + 8'(IX_P0), 8'h03);
      wr(A_ALT + 8'(IX_P3), 8'hFF);
      wr(A_MODE + 8'(IX_P2), 8'h3F);
      wr(A_ALT + 8'(IX_P2), 8'hE0);
      wr(A_MODE + 8'(IX_P7), 8'hFD);
      wr(A_ALT + 8'(IX_P7), 8'h07);
      idle(4);
      chk("t16_in", 72'(2'b10), 72'({cnt_clk, trig}));
      chk("t8_in", 72'(2'b10), 72'({t8a, t8b}));
      chk("p3_oe", 72'(P3_ALT_OUT), 72'(pin_oe_o[24 +: 8]));
      chk("p3_out", 72'(8'h25), 72'(pin_out_o[24 +: 8]));
      chk("p7", 72'(4'hB), 72'({s2d, aclk, pin_oe_o[33], pin_out_o[33]}));
      chk("p2", 72'(4'hF), 72'({s0d, s0c, pin_out_o[22], pin_out_o[23]}));
      wr(A_ALT + 8'(IX_P3), 8'h00);
      idle(3);
      chk("p3_port", 72'(8'h00), 72'(pin_oe_o[24 +: 8]));
      // Second reset in mid-run
      rst_b_i <= 1'b0;
      idle(2);
      rst_b_i <= 1'b1;
      idle(2);
      chk("oe_rst", '0, pin_oe_o);
      rd(A_ALT + 8'(IX_P7), 8'h00);
      idle(3);
      conclude();
   end
endmodule : tb_top
